// ---- bench/ssq_ctl_model.sv ----
// Memory controller model driving strobes, selects and write controls
`timescale 1ns/1ps
module ssq_ctl_model(
	input wire logic clk,
	output logic ps_n, cs_n, adv_n, en_n, hi, aux_n, gate_n, gw_n, oe_n,
	output logic [3:0] bw_n
);
	initial {ps_n, cs_n, adv_n, en_n, hi, aux_n, gate_n, gw_n, oe_n, bw_n} = 13'h1EF0 | 13'h000F;
	// Held from falling edge across the rising edge
	task automatic drive(input logic p, c, s, g, input logic [3:0] b);
		@(negedge clk);
		{ps_n, cs_n, en_n, hi, aux_n, gate_n, bw_n, oe_n} <= {p, c, !s, s, !s, g, b, 1'b0};
	endtask
	// Burst advance and global write, changed on the falling edge
	task automatic misc(input logic a, w);
		@(negedge clk);
		{adv_n, gw_n} <= {a, w};
	endtask
endmodule

// ---- bench/ssq_sva.sv ----
// Port checker for the sleep and cycle qualify block
`timescale 1ns/1ps
module ssq_chk
	import ssq_pkg::*;
#(
	parameter int LANES = 4,
	parameter int LANE_BITS = 8
) (
	input wire logic core_clk_in, sys_rst_in, sleep_request_in,
	input wire logic proc_addr_strobe_n_in, ctrl_addr_strobe_n_in, burst_advance_n_in,
	input wire logic chip_enable_n_in, chip_select_hi_in, chip_select_aux_n_in,
	input wire logic [LANES-1:0] byte_write_en_n_in, lane_write_out,
	input wire logic byte_write_gate_n_in, global_write_n_in, output_enable_n_in,
	input wire logic sleeping_out, selected_out, read_cycle_out, write_cycle_out, data_drive_out, burst_advance_out,
	input wire logic [LANES*(LANE_BITS+1)-1:0] bit_write_out
);
	wire logic cs = !chip_enable_n_in && chip_select_hi_in && !chip_select_aux_n_in;
	wire logic wq = !global_write_n_in || (!byte_write_gate_n_in && !(&byte_write_en_n_in));
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	// Edge open for sampling: no request, not asleep, wake gap over
	sequence open_s;
		!sleep_request_in && !sleeping_out && !$past(sleeping_out) && !$past(sleeping_out, 2);
	endsequence
	chk_read_qual: assert property (open_s ##0 (cs && (!proc_addr_strobe_n_in || (!ctrl_addr_strobe_n_in && !wq)))
		|=> read_cycle_out && !write_cycle_out) else $error("read not qualified");
	chk_write_qual: assert property (open_s ##0 (cs && proc_addr_strobe_n_in && !ctrl_addr_strobe_n_in && wq)
		|=> write_cycle_out && !read_cycle_out) else $error("write not qualified");
	chk_proc_read: assert property (!proc_addr_strobe_n_in |=> !write_cycle_out) else $error("proc strobe wrote");
	chk_sleep_idle: assert property (sleep_request_in |=> !read_cycle_out && !write_cycle_out && !selected_out)
		else $error("sampled in sleep");
	chk_sleep_entry: assert property (sleep_request_in [*5] |-> sleeping_out) else $error("no sleep");
	chk_sleep_exit: assert property (!sleep_request_in [*5] |-> !sleeping_out) else $error("sleep stuck");
	chk_oe_write: assert property (write_cycle_out |-> !data_drive_out) else $error("drive on write");
	chk_oe_read: assert property (read_cycle_out && !output_enable_n_in && !sleep_request_in && !sleeping_out
		|-> data_drive_out) else $error("no drive on read");
	chk_lane_map: assert property (write_cycle_out |-> bit_write_out[8:0] == {9{lane_write_out[0]}})
		else $error("lane a map");
	chk_wake_desel: assert property ($fell(sleeping_out) |-> !selected_out ##1 !read_cycle_out)
		else $error("wake selected");
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the sleep and cycle qualify block
`timescale 1ns/1ps
module tb_top;
	logic clk = 0, rst = 1, zz = 0;
	wire logic ps_n, cs_n, adv_n, en_n, hi, aux_n, gate_n, gw_n, oe_n, slp, sel, rd, wr, drv, adv;
	wire logic [3:0] bw_n, ln;
	wire logic [35:0] bits;
	int num_errors = 0, checked = 0;
	initial forever #10 clk = !clk;
	ssq_ctl_model ctl_u(.clk, .ps_n, .cs_n, .adv_n, .en_n, .hi, .aux_n, .gate_n, .gw_n, .oe_n, .bw_n);
	ssq_core dut_u(.core_clk_in(clk), .sys_rst_in(rst), .sleep_request_in(zz), .proc_addr_strobe_n_in(ps_n),
		.ctrl_addr_strobe_n_in(cs_n), .burst_advance_n_in(adv_n), .chip_enable_n_in(en_n), .chip_select_hi_in(hi),
		.chip_select_aux_n_in(aux_n), .byte_write_en_n_in(bw_n), .byte_write_gate_n_in(gate_n),
		.global_write_n_in(gw_n), .output_enable_n_in(oe_n), .sleeping_out(slp), .selected_out(sel),
		.read_cycle_out(rd), .write_cycle_out(wr), .lane_write_out(ln), .bit_write_out(bits),
		.data_drive_out(drv), .burst_advance_out(adv));
	task automatic chk(input logic ok, input string what);
		checked++;
		if (!ok) begin
			num_errors++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask
	task automatic step(input logic p, c, s, g, input logic [3:0] b);
		ctl_u.drive(p, c, s, g, b);
		@(posedge clk) #1;
	endtask
	task automatic t_cycles;
		step(0, 1, 1, 0, 4'h0);
		chk(rd === 1 && wr === 0 && sel === 1 && drv === 1, "proc read");
		step(1, 1, 1, 0, 4'hE);
		chk(wr === 1 && rd === 0 && drv === 0 && ln === 4'h1 && bits === 36'h0000001FF, "write a");
		step(1, 0, 1, 0, 4'hF);
		chk(rd === 1 && wr === 0, "ctrl read");
	endtask
	task automatic t_sleep;
		step(1, 1, 0, 1, 4'hF);
		@(negedge clk) zz = 1;
		step(0, 1, 1, 0, 4'h0);
		chk(rd === 0 && sel === 0, "gated");
		repeat (5) @(posedge clk);
		#1 chk(slp === 1 && rd === 0, "asleep");
		@(negedge clk) zz = 0;
		repeat (6) step(1, 1, 1, 0, 4'hE);
		chk(slp === 0 && sel === 0 && wr === 0, "wake");
		step(0, 1, 1, 1, 4'hF);
		chk(rd === 1, "fresh read");
	endtask
	task automatic t_global;
		ctl_u.misc(1'b0, 1'b0);
		step(1, 1, 1, 1, 4'hF);
		chk(wr === 1 && ln === 4'hF && bits === {36{1'b1}} && adv === 1 && drv === 0, "global write");
		ctl_u.misc(1'b1, 1'b1);
		step(1, 1, 1, 1, 4'hF);
		chk(rd === 1 && wr === 0 && adv === 0 && drv === 1, "continue read");
	endtask
	task automatic end_of_test;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		@(negedge clk) rst = 0;
		t_cycles;
		t_sleep;
		t_global;
		end_of_test;
	end
endmodule
bind ssq_core ssq_chk #(.LANES(LANES), .LANE_BITS(LANE_BITS)) chk_u(.*);

// ---- logic/ssq_core.sv ----
// Cycle qualification and sleep control of a flow-through burst SRAM
//
// Operation
// - Output enable is ignored on qualified write cycles and while the sleep gate is closed.
// - Edge is a read when global write and all byte enables high or processor strobe low.
// - Edge is a write only with global write or a gated byte enable low and processor strobe high.
// - Chip selects sampled at strobe edges; invalid selects deselect the device.
// - During sleep the device is deselected and in low-current state.
// - Sleep state is entered and left four clock edges after the sleep request rises or falls.
// - In sleep every input except the sleep request is ignored.
// - Sleep request is active high and asynchronous to the clock.
// - An access in progress at sleep entry may be lost.
// - Sampling stops within one clock period after sleep request rises.
// - Write qualifier inactive when global write high and either the gate or all enables high.
// - Each byte write enable controls one data lane and its parity bit.
// - Processor strobe low starts a read; writes need enables next edge.
`timescale 1ns/1ps
module ssq_core
	import ssq_pkg::*;
#(
	parameter int LANES = SSQ_LANES,
	parameter int LANE_BITS = SSQ_LANE_BITS
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	// Sleep request, asynchronous
	input wire logic sleep_request_in,
	// Address strobes and burst control
	input wire logic proc_addr_strobe_n_in,
	input wire logic ctrl_addr_strobe_n_in,
	input wire logic burst_advance_n_in,
	// Chip enables
	input wire logic chip_enable_n_in,
	input wire logic chip_select_hi_in,
	input wire logic chip_select_aux_n_in,
	// Write controls
	input wire logic [LANES-1:0] byte_write_en_n_in,
	input wire logic byte_write_gate_n_in,
	input wire logic global_write_n_in,
	input wire logic output_enable_n_in,
	// Qualified cycle status
	output logic sleeping_out,
	output logic selected_out,
	output logic read_cycle_out,
	output logic write_cycle_out,
	output logic [LANES-1:0] lane_write_out,
	output logic [LANES*(LANE_BITS+1)-1:0] bit_write_out,
	output logic data_drive_out,
	output logic burst_advance_out
);
	typedef enum logic [1:0] {
		SSQ_SLP_AWAKE = 2'b00,
		SSQ_SLP_ASLEEP = 2'b01,
		SSQ_SLP_WAKE = 2'b10
	} ssq_sleep_t;

	// Sleep request sampler
	logic [2:0] zz_sync_q;
	logic [2:0] zz_sync_d;
	logic zz_agree;
	logic zz_level;

	// Sleep state and exit delay
	ssq_sleep_t sleep_st_q;
	ssq_sleep_t sleep_st_d;
	logic [1:0] wake_cnt_q;
	logic [1:0] wake_cnt_d;
	logic gate_in;

	// Synchronous inputs after the sleep gate
	logic proc_strobe_n_g;
	logic ctrl_strobe_n_g;
	logic burst_advance_n_g;
	logic chip_enable_n_g;
	logic chip_select_hi_g;
	logic chip_select_aux_n_g;
	logic byte_write_gate_n_g;
	logic global_write_n_g;
	logic [LANES-1:0] byte_write_en_n_g;

	// Strobe and qualifier decode
	logic proc_strobe;
	logic ctrl_strobe;
	logic any_strobe;
	logic cs_ok;
	logic start_ok;
	logic cont_ok;
	logic wr_qual;
	logic [LANES-1:0] lane_en;

	// Registered cycle status
	logic selected_q;
	logic selected_d;
	ssq_cycle_t cycle_q;
	ssq_cycle_t cycle_d;
	logic [LANES-1:0] lane_q;
	logic [LANES-1:0] lane_d;
	logic adv_q;
	logic adv_d;

	// Three stages; a new level counts once stages two and three agree
	always_comb begin
		zz_sync_d = {zz_sync_q[1:0], sleep_request_in};
		zz_agree = (zz_sync_q[2] == zz_sync_q[1]);
		zz_level = zz_sync_q[2];
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			zz_sync_q <= 3'h0;
		end else begin
			zz_sync_q <= zz_sync_d;
		end
	end

	// Awake, asleep, or held off for the exit delay after the request falls
	always_comb begin
		sleep_st_d = sleep_st_q;
		wake_cnt_d = wake_cnt_q;
		case (sleep_st_q)
			SSQ_SLP_AWAKE: begin
				wake_cnt_d = 2'h0;
				if (zz_agree && zz_level) begin
					sleep_st_d = SSQ_SLP_ASLEEP;
				end
			end

			SSQ_SLP_ASLEEP: begin
				wake_cnt_d = 2'h0;
				if (zz_agree && !zz_level) begin
					sleep_st_d = SSQ_SLP_WAKE;
					wake_cnt_d = 2'(SSQ_SLEEP_EXIT_CYC);
				end
			end

			SSQ_SLP_WAKE: begin
				if (zz_agree && zz_level) begin
					sleep_st_d = SSQ_SLP_ASLEEP;
					wake_cnt_d = 2'h0;
				end else if (wake_cnt_q <= 2'h1) begin
					sleep_st_d = SSQ_SLP_AWAKE;
					wake_cnt_d = 2'h0;
				end else begin
					wake_cnt_d = wake_cnt_q - 2'h1;
				end
			end

			default: begin
				// Unused code: recover to awake
				sleep_st_d = SSQ_SLP_AWAKE;
				wake_cnt_d = 2'h0;
			end
		endcase
	end

	// Sleep state register
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sleep_st_q <= SSQ_SLP_AWAKE;
		end else begin
			sleep_st_q <= sleep_st_d;
		end
	end

	// Exit delay counter
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wake_cnt_q <= SSQ_SYNC_RST;
		end else begin
			wake_cnt_q <= wake_cnt_d;
		end
	end

	// The pin closes the gate at once; the state keeps it closed through sleep and the exit delay
	assign gate_in = sleep_request_in || (sleep_st_q != SSQ_SLP_AWAKE);

	// Strobes and selects forced to their idle levels while gated
	always_comb begin
		proc_strobe_n_g = proc_addr_strobe_n_in || gate_in;
		ctrl_strobe_n_g = ctrl_addr_strobe_n_in || gate_in;
		burst_advance_n_g = burst_advance_n_in || gate_in;
		chip_enable_n_g = chip_enable_n_in || gate_in;
		chip_select_hi_g = chip_select_hi_in && !gate_in;
		chip_select_aux_n_g = chip_select_aux_n_in || gate_in;
	end

	// Write controls forced inactive while gated
	always_comb begin
		byte_write_gate_n_g = byte_write_gate_n_in || gate_in;
		global_write_n_g = global_write_n_in || gate_in;
		byte_write_en_n_g = byte_write_en_n_in | {LANES{gate_in}};
	end

	// Per-lane write enable: global write, or the gate with the lane's own enable
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane_en
			assign lane_en[g] = !global_write_n_g || (!byte_write_gate_n_g && !byte_write_en_n_g[g]);
		end
	endgenerate

	always_comb begin
		proc_strobe = !proc_strobe_n_g;
		ctrl_strobe = !ctrl_strobe_n_g;
		any_strobe = proc_strobe || ctrl_strobe;
		cs_ok = !chip_enable_n_g && chip_select_hi_g && !chip_select_aux_n_g;
	end

	// A new access needs valid selects; a continuation rides on the held selection
	always_comb begin
		wr_qual = |lane_en;
		start_ok = any_strobe && cs_ok;
		cont_ok = !any_strobe && selected_q;
	end

	// A processor strobe with valid selects reads; otherwise the write qualifier decides
	always_comb begin
		selected_d = selected_q;
		cycle_d = SSQ_CYC_IDLE;
		lane_d = '0;
		adv_d = 1'b0;
		if (gate_in) begin
			selected_d = 1'b0;
		end else begin
			if (any_strobe) begin
				selected_d = cs_ok;
			end
			if (proc_strobe) begin
				if (cs_ok) begin
					cycle_d = SSQ_CYC_READ;
				end
			end else if (start_ok || cont_ok) begin
				if (wr_qual) begin
					cycle_d = SSQ_CYC_WRITE;
					lane_d = lane_en;
				end else begin
					cycle_d = SSQ_CYC_READ;
				end
				adv_d = cont_ok && !burst_advance_n_g;
			end
		end
	end

	// Selection holds until the next strobe edge or sleep
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			selected_q <= 1'b0;
		end else begin
			selected_q <= selected_d;
		end
	end

	// Cycle kind stands for one clock
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cycle_q <= SSQ_CYC_IDLE;
		end else begin
			cycle_q <= cycle_d;
		end
	end

	// Lanes written on that cycle
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			lane_q <= '0;
		end else begin
			lane_q <= lane_d;
		end
	end

	// Burst advance seen on a continuation edge
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			adv_q <= 1'b0;
		end else begin
			adv_q <= adv_d;
		end
	end

	// Each lane writes its data bits and its parity bit together
	genvar b;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane_bits
			for (b = 0; b < LANE_BITS; b++) begin : g_data
				assign bit_write_out[g*(LANE_BITS+1)+b] = lane_q[g];
			end
			assign bit_write_out[g*(LANE_BITS+1)+LANE_BITS] = lane_q[g];
		end
	endgenerate

	assign sleeping_out = (sleep_st_q == SSQ_SLP_ASLEEP);
	assign selected_out = selected_q;

	assign read_cycle_out = (cycle_q == SSQ_CYC_READ);
	assign write_cycle_out = (cycle_q == SSQ_CYC_WRITE);
	assign lane_write_out = lane_q;
	assign burst_advance_out = adv_q;

	// Output drive follows OE only on read cycles; writes override it
	assign data_drive_out = (cycle_q == SSQ_CYC_READ) && !output_enable_n_in && !gate_in;
endmodule

// ---- logic/ssq_pkg.sv ----
// Constants for the sleep and cycle qualify block of a flow-through burst SRAM
package ssq_pkg;
	localparam int SSQ_LANES = 4;
	localparam int SSQ_LANE_BITS = 8;
	localparam int SSQ_CLK_PERIOD_NS = 20;
	// Sleep exit: at least one clock period before inputs are sampled again
	localparam int SSQ_SLEEP_EXIT_NS = 20;
	localparam int SSQ_SLEEP_EXIT_CYC = (SSQ_SLEEP_EXIT_NS + SSQ_CLK_PERIOD_NS - 1) / SSQ_CLK_PERIOD_NS;
	localparam logic [1:0] SSQ_SYNC_RST = 2'h0;
	typedef enum logic [1:0] {
		SSQ_CYC_IDLE = 2'b00,
		SSQ_CYC_READ = 2'b01,
		SSQ_CYC_WRITE = 2'b10
	} ssq_cycle_t;
endpackage
